// ---- hdl/irq_view_pkg.sv ----
// constants shared by the masked interrupt status view and its pin filter
package irq_view_pkg;

    // ==========================================================
    // bus and word geometry
    localparam int unsigned DATA_W = 32;
    localparam int unsigned SYNC_STAGES = 3;

    // ==========================================================
    // register byte offsets on the bus
    localparam logic [4:0] OFF_RAW = 5'h00;
    localparam logic [4:0] OFF_ENABLE = 5'h04;
    localparam logic [4:0] OFF_MASKED = 5'h08;
    localparam logic [4:0] OFF_TRIGGER = 5'h0c;
    localparam logic [4:0] OFF_POLARITY = 5'h10;

    // ==========================================================
    // source bit positions in every status word
    localparam int unsigned POS_UART_FIRST = 0;
    localparam int unsigned POS_UART_SECOND = 1;
    localparam int unsigned POS_TWO_WIRE = 2;
    localparam int unsigned POS_PCI = 3;
    localparam int unsigned POS_DMA_BASE = 5;
    localparam int unsigned POS_ETH_WAKE = 9;
    localparam int unsigned POS_LAYER_BASE = 10;
    localparam int unsigned POS_MAC_FIRST = 15;
    localparam int unsigned POS_EXT_PCI_SYSERR = 16;
    localparam int unsigned POS_MAC_SECOND = 17;
    localparam int unsigned POS_GP_TIMER_BASE = 19;
    localparam int unsigned POS_EXT_REQ_BASE = 25;

    // ==========================================================
    // implemented bits; positions 4, 18 and 24 carry no source
    localparam logic [31:0] VALID_MASK = 32'hfefb_ffef;

    // ==========================================================
    // values after reset
    localparam logic [31:0] RAW_RST = 32'h0000_0000;
    localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
    localparam logic [31:0] TRIGGER_RST = 32'h0000_0000;
    localparam logic [31:0] POLARITY_RST = 32'hfefb_ffef;

    // ==========================================================
    // bus response codes
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ---- hdl/pin_filter.sv ----
// three-stage synchroniser with agreement filter for asynchronous request pins
`timescale 1ns/1ns
module pin_filter
    import irq_view_pkg::*;
#(
    parameter int unsigned WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] level
);

    // ==========================================================
    // elaboration check
    if (WIDTH < 1) begin : g_width_check
        $error("pin_filter needs at least one pin");
    end

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] level_reg;

    // ==========================================================
    // synchroniser chain; stage1 feeds only stage2
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end else begin
            stage1_reg <= pin_async;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // ==========================================================
    // a change counts only once stages two and three agree
    for (genvar i = 0; i < WIDTH; i++) begin : g_filter
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                level_reg[i] <= 1'b0;
            end else if (stage2_reg[i] == stage3_reg[i]) begin
                level_reg[i] <= stage3_reg[i];
            end
        end
    end

    assign level = level_reg;

endmodule

// ---- hdl/masked_interrupt_status_view.sv ----
// masked interrupt status view of the interrupt controller, with AXI4-Lite access
// Register map, one aligned 32-bit word each
// 0x00 raw status: read, write one to clear
// 0x04 enable mask
// 0x08 masked status: read only, writes land nowhere
// 0x0c trigger select per source: 0 level, 1 edge
// 0x10 request polarity per source: 1 active high
// any other word offset answers with a slave error; byte offsets inside a word decode to that word
//
// Timing
// raw status follows an on-chip request one edge later
// external pins add four edges of filtering
// the masked port lags the bus view by one edge
// a write lands one edge after both its halves are held
// read data stand in a register one edge after the address
`timescale 1ns/1ns
module masked_interrupt_status_view
    import irq_view_pkg::*;
#(
    parameter int unsigned ADDR_W = 5
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    // on-chip sources, same clock
    input wire logic [1:0] uart_irq,
    input wire logic two_wire_irq,
    input wire logic pci_irq,
    input wire logic [3:0] dma_irq,
    input wire logic eth_wake_irq,
    input wire logic [4:0] layer_irq,
    input wire logic [1:0] mac_irq,
    input wire logic [4:0] gp_timer_irq,
    // pins from outside the clock domain
    input wire logic ext_pci_syserr_pin,
    input wire logic [6:0] ext_req_pin,
    // registered copy of the masked word
    output logic [31:0] masked_status_word,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ==========================================================
    // elaboration check
    if (ADDR_W < 5) begin : g_addr_check
        $error("ADDR_W must be at least 5 to reach every register");
    end

    // ==========================================================
    // declarations
    // status path
    logic [7:0] pin_level;
    logic [31:0] src_vec;
    logic [31:0] asserted;
    logic [31:0] asserted_prev_reg;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic [31:0] raw_reg;
    logic [31:0] raw_next;
    logic [31:0] enable_reg;
    logic [31:0] trigger_reg;
    logic [31:0] polarity_reg;
    logic [31:0] masked_now;
    logic [31:0] masked_reg;
    logic [31:0] byte_mask;
    logic [31:0] write_bits;
    // bus holding state
    logic aw_held_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic do_write;
    logic do_read;
    logic [31:0] read_word;
    logic read_hit;
    logic write_hit;

    // ==========================================================
    // address decode helpers
    function automatic logic in_map(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] upper;
        upper = addr >> 5;
        in_map = (upper == '0);
    endfunction

    function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [4:0] off);
        hits = in_map(addr) && (addr[4:2] == off[4:2]);
    endfunction

    // ==========================================================
    // external pins pass the agreement filter first
    // on-chip sources share this clock and skip the filter
    pin_filter #(
        .WIDTH(8)
    ) u_pin_filter (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_async({ext_pci_syserr_pin, ext_req_pin}),
        .level(pin_level)
    );

    // ==========================================================
    // fixed source-to-bit assignment
    // unassigned positions stay tied low, and raw_next gates them with VALID_MASK so they can never set
    always_comb begin
        src_vec = '0;
        src_vec[POS_UART_FIRST] = uart_irq[0];
        src_vec[POS_UART_SECOND] = uart_irq[1];
        src_vec[POS_TWO_WIRE] = two_wire_irq;
        src_vec[POS_PCI] = pci_irq;
        for (int i = 0; i < 4; i++) begin
            src_vec[POS_DMA_BASE + i] = dma_irq[i];
        end
        src_vec[POS_ETH_WAKE] = eth_wake_irq;
        for (int i = 0; i < 5; i++) begin
            src_vec[POS_LAYER_BASE + i] = layer_irq[i];
        end
        src_vec[POS_MAC_FIRST] = mac_irq[0];
        src_vec[POS_EXT_PCI_SYSERR] = pin_level[7];
        src_vec[POS_MAC_SECOND] = mac_irq[1];
        for (int i = 0; i < 5; i++) begin
            src_vec[POS_GP_TIMER_BASE + i] = gp_timer_irq[i];
        end
        for (int i = 0; i < 7; i++) begin
            src_vec[POS_EXT_REQ_BASE + i] = pin_level[i];
        end
    end

    // ==========================================================
    // write strobe expansion to a bit mask
    for (genvar b = 0; b < 4; b++) begin : g_strb
        assign byte_mask[8*b +: 8] = {8{w_strb_reg[b]}};
    end

    assign write_bits = w_data_reg & byte_mask;

    // ==========================================================
    // write channel handshake: address and data taken in either order
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign write_hit = hits(aw_addr_reg, OFF_RAW) || hits(aw_addr_reg, OFF_ENABLE)
        || hits(aw_addr_reg, OFF_MASKED) || hits(aw_addr_reg, OFF_TRIGGER)
        || hits(aw_addr_reg, OFF_POLARITY);

    // address holding register
    // held until the data half arrives, so either may come first
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    // data holding register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            w_held_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    // write response; unmapped offsets answer with a slave error
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= write_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // ==========================================================
    // software-steered configuration
    // the masked word has no storage, so a write there simply lands nowhere
    // polarity or trigger changes act at once and may set a raw bit
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            enable_reg <= ENABLE_RST;
        end else if (do_write && hits(aw_addr_reg, OFF_ENABLE)) begin
            enable_reg <= ((enable_reg & ~byte_mask) | write_bits) & VALID_MASK;
        end
    end

    // trigger selection per source, 0 level and 1 edge
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            trigger_reg <= TRIGGER_RST;
        end else if (do_write && hits(aw_addr_reg, OFF_TRIGGER)) begin
            trigger_reg <= ((trigger_reg & ~byte_mask) | write_bits) & VALID_MASK;
        end
    end

    // asserted polarity per source, 1 active high
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            polarity_reg <= POLARITY_RST;
        end else if (do_write && hits(aw_addr_reg, OFF_POLARITY)) begin
            polarity_reg <= ((polarity_reg & ~byte_mask) | write_bits) & VALID_MASK;
        end
    end

    // ==========================================================
    // raw status: write one to clear, set always wins
    // a clear that meets a set in the same cycle is lost on purpose,
    // so software re-reads rather than trusting the write
    assign clr_vec = (do_write && hits(aw_addr_reg, OFF_RAW)) ? write_bits : '0;

    for (genvar i = 0; i < 32; i++) begin : g_raw
        assign asserted[i] = polarity_reg[i] ? src_vec[i] : !src_vec[i];
        // level mode keeps setting while asserted, which defeats any clear
        assign set_vec[i] = trigger_reg[i] ? (asserted[i] && !asserted_prev_reg[i])
            : asserted[i];
        assign raw_next[i] = VALID_MASK[i] && (set_vec[i] || (raw_reg[i] && !clr_vec[i]));
    end

    // previous asserted level for edge detection
    // a source already asserted as reset lifts counts as an edge
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            asserted_prev_reg <= '0;
        end else begin
            asserted_prev_reg <= asserted;
        end
    end

    // sticky raw status bits
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            raw_reg <= RAW_RST;
        end else begin
            raw_reg <= raw_next;
        end
    end

    // ==========================================================
    // masked view, read live and also kept in a register for the port
    // the bus sees the live value; the port costs one edge of latency
    assign masked_now = raw_reg & enable_reg & VALID_MASK;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            masked_reg <= '0;
        end else begin
            masked_reg <= masked_now;
        end
    end

    assign masked_status_word = masked_reg;

    // ==========================================================
    // read channel: one read in flight, data from a register
    assign s_axi_arready = !rvalid_reg;
    assign do_read = s_axi_arvalid && s_axi_arready;

    // read multiplexer
    // reserved bits need no masking here, no register ever stores them
    always_comb begin
        read_word = '0;
        read_hit = 1'b1;
        if (hits(s_axi_araddr, OFF_RAW)) begin
            read_word = raw_reg;
        end else if (hits(s_axi_araddr, OFF_ENABLE)) begin
            read_word = enable_reg;
        end else if (hits(s_axi_araddr, OFF_MASKED)) begin
            read_word = masked_now;
        end else if (hits(s_axi_araddr, OFF_TRIGGER)) begin
            read_word = trigger_reg;
        end else if (hits(s_axi_araddr, OFF_POLARITY)) begin
            read_word = polarity_reg;
        end else begin
            read_hit = 1'b0;
        end
    end

    // read data and response held until the master takes them
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else if (do_read) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= read_word;
            rresp_reg <= read_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

endmodule

// ---- verif/masked_view_checker.sv ----
// bus and status assertions for the masked interrupt status view
`timescale 1ns/1ns
module masked_view_checker
    import irq_view_pkg::*;
#(
    parameter int unsigned ADDR_W = 5
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [1:0] uart_irq,
    input wire logic [31:0] masked_status_word,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [ADDR_W-1:0] rd_addr_reg;

    // offset of the read in flight, so read data can be judged by register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_addr_reg <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_reg <= s_axi_araddr;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // status word
    a_rsv_port_zero: assert property ((masked_status_word & ~VALID_MASK) == 32'h0)
        else $error("reserved bit set on masked port");
    a_rsv_read_zero: assert property (s_axi_rvalid && rd_addr_reg == OFF_MASKED |->
        (s_axi_rdata & ~VALID_MASK) == 32'h0 && s_axi_rresp == RESP_OKAY) else $error("masked read bad");
    // uart first is never set to edge mode by the bench, so a held request keeps its bit
    a_level_sticky: assert property (masked_status_word[0] && uart_irq[0] && $past(uart_irq[0]) |=>
        masked_status_word[0]) else $error("level bit cleared while request held");

    // ==========================================================
    // register bus
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
endmodule

bind masked_interrupt_status_view masked_view_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

// ---- verif/irq_sources.sv ----
// far-side interrupt sources, driven from one request word in status bit order
`timescale 1ns/1ns
module irq_sources (
    input wire logic [31:0] req_word,
    output logic [1:0] uart_irq,
    output logic two_wire_irq,
    output logic pci_irq,
    output logic [3:0] dma_irq,
    output logic eth_wake_irq,
    output logic [4:0] layer_irq,
    output logic [1:0] mac_irq,
    output logic [4:0] gp_timer_irq,
    output logic ext_pci_syserr_pin,
    output logic [6:0] ext_req_pin
);
    // requests are levels held by the bench; some status clears are written while the source is still asserted
    assign uart_irq = req_word[1:0];
    assign two_wire_irq = req_word[2];
    assign pci_irq = req_word[3];
    assign dma_irq = req_word[8:5];
    assign eth_wake_irq = req_word[9];
    assign layer_irq = req_word[14:10];
    assign mac_irq = {req_word[17], req_word[15]};
    assign ext_pci_syserr_pin = req_word[16];
    assign gp_timer_irq = req_word[23:19];
    assign ext_req_pin = req_word[31:25];
endmodule

// ---- verif/masked_interrupt_status_view_test.sv ----
// self-checking bench for the masked interrupt status view
`timescale 1ns/1ns
module masked_interrupt_status_view_test;
    import irq_view_pkg::*;
    logic clk_sys, rst_n;
    logic [31:0] req_word, masked_status_word, s_axi_wdata, s_axi_rdata;
    logic [1:0] uart_irq, mac_irq, s_axi_bresp, s_axi_rresp;
    logic two_wire_irq, pci_irq, eth_wake_irq, ext_pci_syserr_pin;
    logic [3:0] dma_irq, s_axi_wstrb;
    logic [4:0] layer_irq, gp_timer_irq, s_axi_awaddr, s_axi_araddr;
    logic [6:0] ext_req_pin;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int error_cnt, checks;

    masked_interrupt_status_view dut (.*);
    irq_sources src (.*);

    // free-running system clock
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // compare, bus and closing tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // ready is raised only once the answer shows, so the answer must stand meanwhile
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done, w_done;
        @(posedge clk_sys);
        aw_done = 1'h0;
        w_done = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!(aw_done && w_done)) begin
            @(posedge clk_sys);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge clk_sys); while (!s_axi_bvalid);
        s_axi_bready <= 1'h1;
        @(posedge clk_sys);
        s_axi_bready <= 1'h0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rd(input string what, input logic [4:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk_sys); while (!s_axi_rvalid);
        s_axi_rready <= 1'h1;
        @(posedge clk_sys);
        s_axi_rready <= 1'h0;
        chk(what, s_axi_rdata, exp);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, RESP_OKAY});
    endtask

    task automatic end_of_test;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog at 20000 cycles, well beyond the thousand or so cycles the run needs
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end

    // ==========================================================
    // test sequence
    initial begin
        rst_n = 1'h0;
        req_word = 32'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 5'h0;
        s_axi_araddr = 5'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        error_cnt = 0;
        checks = 0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'h1;
        // reset values of every register
        rd("raw", OFF_RAW, RAW_RST);
        rd("enable", OFF_ENABLE, ENABLE_RST);
        rd("masked", OFF_MASKED, 32'h0);
        rd("trigger", OFF_TRIGGER, TRIGGER_RST);
        rd("polarity", OFF_POLARITY, POLARITY_RST);
        wr(OFF_ENABLE, 32'hffff_ffff, RESP_OKAY);
        rd("enable", OFF_ENABLE, VALID_MASK);
        // one source at a time; eight cycles cover the pin filter latency
        for (int i = 0; i < 32; i++) begin
            if (VALID_MASK[i]) begin
                @(posedge clk_sys);
                req_word <= 32'h1 << i;
                tick(8);
                rd("masked bit", OFF_MASKED, 32'h1 << i);
                req_word <= 32'h0;
                tick(8);
                wr(OFF_RAW, 32'h1 << i, RESP_OKAY);
                rd("bit cleared", OFF_MASKED, 32'h0);
            end
        end
        // all sources held against a partial mask
        wr(OFF_ENABLE, 32'h00f0_0f0f, RESP_OKAY);
        req_word <= 32'hffff_ffff;
        tick(8);
        rd("raw all", OFF_RAW, VALID_MASK);
        rd("masked part", OFF_MASKED, VALID_MASK & 32'h00f0_0f0f);
        chk("masked port", masked_status_word, VALID_MASK & 32'h00f0_0f0f);
        wr(OFF_RAW, 32'hffff_ffff, RESP_OKAY);
        rd("raw held", OFF_RAW, VALID_MASK);
        // dma channel 0 in edge mode clears although still requested
        wr(OFF_TRIGGER, 32'h0000_0020, RESP_OKAY);
        rd("trigger", OFF_TRIGGER, 32'h0000_0020);
        wr(OFF_RAW, 32'h0000_0020, RESP_OKAY);
        rd("edge cleared", OFF_RAW, VALID_MASK & ~32'h0000_0020);
        req_word <= 32'h0;
        tick(8);
        wr(OFF_RAW, 32'hffff_ffff, RESP_OKAY);
        rd("raw released", OFF_RAW, 32'h0);
        // masked word ignores writes, unmapped offset is refused
        wr(OFF_MASKED, 32'hffff_ffff, RESP_OKAY);
        rd("masked kept", OFF_MASKED, 32'h0);
        wr(5'h14, 32'hffff_ffff, RESP_SLVERR);
        rd("enable kept", OFF_ENABLE, 32'h00f0_0f0f);
        // byte strobes: only the lowest byte of the enable mask is written
        s_axi_wstrb <= 4'h1;
        wr(OFF_ENABLE, 32'hffff_0022, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd("enable byte", OFF_ENABLE, 32'h00f0_0f22);
        // active-low request on uart second, one-cycle pulse on edge-mode dma channel 0
        wr(OFF_POLARITY, VALID_MASK & ~32'h0000_0002, RESP_OKAY);
        req_word <= 32'h0000_0020;
        @(posedge clk_sys);
        req_word <= 32'h0;
        tick(2);
        rd("pulse and low", OFF_MASKED, 32'h0000_0022);
        wr(OFF_RAW, 32'h0000_0022, RESP_OKAY);
        rd("low held", OFF_RAW, 32'h0000_0002);
        wr(OFF_POLARITY, POLARITY_RST, RESP_OKAY);
        wr(OFF_RAW, 32'h0000_0002, RESP_OKAY);
        rd("low released", OFF_MASKED, 32'h0);
        end_of_test();
    end
endmodule
